// ---- inc/pcdma_pkg.sv ----
// Contract
// - Table base register holds a 32-byte aligned system memory address.
// - Trigger select: 0 starts by software, 1 starts by hardware.
// - Enable register reads back; 0 disables, 1 enables; disable before reconfiguring.
// - Writing 1 to start launches a transfer; read gives 1 while busy.
// - Completion sets bit 12 of normal status; writing 1 there clears it.
// - Area protection register limits which system memory the engine touches.
// - System control register sets link timeout and bit rate.
// - Entry word 0: port in 17:16, length minus one low, bit 31 last.
// - Entry word 1 is the reply storage address.
// - Reply stored from its header word onward.
// - No connection writes all ones at the reception address.
// - Reception error writes a distinct marker at the reception address.
// - Configuration kept after completion; restart needs only flag clear and start.
package pcdma_pkg;
  // ==========
  // Register byte offsets
  localparam logic [23:0] OFF_NORMAL_STATUS  = 24'h5F6900;
  localparam logic [23:0] OFF_TABLE_BASE     = 24'h5F6C04;
  localparam logic [23:0] OFF_TRIGGER_SELECT = 24'h5F6C10;
  localparam logic [23:0] OFF_ENGINE_ENABLE  = 24'h5F6C14;
  localparam logic [23:0] OFF_START_STATUS   = 24'h5F6C18;
  localparam logic [23:0] OFF_LINK_CONTROL   = 24'h5F6C80;
  localparam logic [23:0] OFF_AREA_PROTECT   = 24'h5F6C8C;
  // ==========
  // Fields and values
  localparam int          DONE_BIT        = 12;
  localparam int          LAST_BIT        = 31;
  localparam int          PORT_LSB        = 16;
  localparam int          LEN_BITS        = 8;
  localparam logic [5:0]  SYSMEM_TOP      = 6'h03;
  localparam logic [31:0] BASE_MASK       = 32'h0FFFFFE0;
  localparam logic [15:0] PROTECT_KEY     = 16'h6155;
  localparam logic [31:0] PROTECT_RESET   = 32'h0000007F;
  localparam logic [31:0] LINK_CTRL_RESET = 32'h00000000;
  localparam logic [31:0] NO_LINK_WORD    = 32'hFFFFFFFF;
  localparam logic [31:0] RX_ERROR_WORD   = 32'hFFFFFF00;
  localparam logic [31:0] UNMAPPED_WORD   = 32'h00000000;
  // ==========
  // Timing: timeout field counts 20 ns units, clock period 40 ns
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          TIMEOUT_UNIT_NS = 20;
  localparam logic [16:0] UNITS_PER_CLK   = 17'(CLK_PERIOD_NS / TIMEOUT_UNIT_NS);
  // ==========
  // Engine states
  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_HDR  = 7'b0000010,
    S_RXA  = 7'b0000100,
    S_RDTX = 7'b0001000,
    S_TX   = 7'b0010000,
    S_RX   = 7'b0100000,
    S_WR   = 7'b1000000
  } engine_state_e;
endpackage

// ---- src/pcdma_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none
module pcdma_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
    $error("pcdma_fifo: DEPTH must be a power of two >= 2");
  end
  // ==========
  // Storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];
  assign count_next = wr_ptr_reg + (AW+1)'(push) - rd_ptr_reg - (AW+1)'(pop);
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      in_ready   <= 1'b0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
      rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
      in_ready   <= (count_next != (AW+1)'(DEPTH));
    end
  end
endmodule // pcdma_fifo
`default_nettype wire

// ---- src/pcdma_rx_select.sv ----
`timescale 1ns/10ps
`default_nettype none
module pcdma_rx_select
  import pcdma_pkg::*;
(
  input  wire logic        rx_error,
  input  wire logic        timed_out,
  input  wire logic        got_word,
  input  wire logic [31:0] rx_word,
  input  wire logic [31:0] base_addr,
  input  wire logic [31:0] write_addr,
  output logic      [31:0] store_addr,
  output logic      [31:0] store_word
);
  // ==========
  // Reply word or fault marker selection
  always_comb begin
    if (rx_error || (timed_out && got_word)) begin
      store_addr = base_addr;
      store_word = RX_ERROR_WORD;
    end else if (timed_out) begin
      store_addr = base_addr;
      store_word = NO_LINK_WORD;
    end else begin
      store_addr = write_addr;
      store_word = rx_word;
    end
  end
endmodule // pcdma_rx_select
`default_nettype wire

// ---- src/peripheral_command_dma.sv ----
`timescale 1ns/10ps
`default_nettype none
module peripheral_command_dma
  import pcdma_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [23:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  output var  logic [31:0] mm_address,
  output var  logic        mm_read,
  output var  logic        mm_write,
  output var  logic [31:0] mm_writedata,
  input  wire logic [31:0] mm_readdata,
  input  wire logic        mm_waitrequest,
  input  wire logic        hw_trigger,
  output var  logic        tx_valid,
  output var  logic [31:0] tx_data,
  output var  logic        tx_last,
  output var  logic [1:0]  tx_port,
  input  wire logic        tx_ready,
  input  wire logic        rx_valid,
  input  wire logic [31:0] rx_data,
  input  wire logic        rx_last,
  input  wire logic        rx_error,
  output var  logic        rx_ready,
  output var  logic [31:0] link_control,
  output var  logic        dma_busy,
  output var  logic        dma_done
);
  if (FIFO_DEPTH < 2) begin : g_bad_param
    $error("FIFO_DEPTH too small");
  end
  // ==========
  // Declarations
  engine_state_e state_reg;
  logic [31:0]   table_base_reg;
  logic          trigger_select_reg;
  logic          engine_enable_reg;
  logic [31:0]   area_protect_reg;
  logic [31:0]   header_reg;
  logic [31:0]   reply_base_reg;
  logic [31:0]   write_ptr_reg;
  logic [31:0]   table_ptr_reg;
  logic [LEN_BITS:0] tx_left_reg;
  logic [16:0]   timeout_reg;
  logic          got_word_reg;
  logic          reply_end_reg;
  logic          wr_fire;
  logic          rd_fire;
  logic          sw_start;
  logic          start;
  logic          fifo_valid;
  logic [33:0]   fifo_data;
  logic          fifo_pop;
  logic          timed_out;
  logic [31:0]   store_addr;
  logic [31:0]   store_word;
  logic          mm_done;

  function automatic logic area_ok(input logic [31:0] addr, input logic [31:0] prot);
    area_ok = (addr[31:26] == SYSMEM_TOP) &&
              (addr[26:20] >= prot[14:8]) && (addr[26:20] <= prot[6:0]);
  endfunction

  // ==========
  // Avalon-MM slave handshake
  assign wr_fire = avs_write && !avs_waitrequest;
  assign rd_fire = avs_read && !avs_waitrequest;
  assign sw_start = wr_fire && (avs_address == OFF_START_STATUS) && avs_byteenable[0]
                    && avs_writedata[0];
  assign start = engine_enable_reg && state_reg == S_IDLE &&
                 ((!trigger_select_reg && sw_start) || (trigger_select_reg && hw_trigger));

  always_ff @(posedge clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      avs_readdata <= UNMAPPED_WORD;
    end else if (avs_read && avs_waitrequest) begin
      unique case (avs_address)
        OFF_NORMAL_STATUS:  avs_readdata <= 32'(dma_done) << DONE_BIT;
        OFF_TABLE_BASE:     avs_readdata <= table_base_reg;
        OFF_TRIGGER_SELECT: avs_readdata <= {31'h0, trigger_select_reg};
        OFF_ENGINE_ENABLE:  avs_readdata <= {31'h0, engine_enable_reg};
        OFF_START_STATUS:   avs_readdata <= {31'h0, dma_busy};
        OFF_LINK_CONTROL:   avs_readdata <= link_control;
        OFF_AREA_PROTECT:   avs_readdata <= area_protect_reg;
        default:            avs_readdata <= UNMAPPED_WORD;
      endcase
    end
  end

  // ==========
  // Configuration registers, kept across transfers
  always_ff @(posedge clk) begin
    if (reset) begin
      table_base_reg     <= 32'h0C000000;
      trigger_select_reg <= 1'b0;
      engine_enable_reg  <= 1'b0;
      link_control       <= LINK_CTRL_RESET;
      area_protect_reg   <= PROTECT_RESET;
    end else if (wr_fire && avs_byteenable == 4'hF) begin
      unique case (avs_address)
        OFF_TABLE_BASE: begin
          if (avs_writedata[31:26] == SYSMEM_TOP) begin
            table_base_reg <= avs_writedata & BASE_MASK | 32'h0C000000;
          end
        end
        OFF_TRIGGER_SELECT: trigger_select_reg <= avs_writedata[0];
        OFF_ENGINE_ENABLE:  engine_enable_reg  <= avs_writedata[0];
        OFF_LINK_CONTROL:   link_control       <= avs_writedata;
        OFF_AREA_PROTECT: begin
          if (avs_writedata[31:16] == PROTECT_KEY) begin
            area_protect_reg <= {16'h0, 1'b0, avs_writedata[14:8], 1'b0, avs_writedata[6:0]};
          end
        end
        default: ;
      endcase
    end
  end

  // ==========
  // Completion flag, set wins over clear
  always_ff @(posedge clk) begin
    if (reset) begin
      dma_done <= 1'b0;
    end else if (state_reg == S_WR && mm_done && reply_end_reg && header_reg[LAST_BIT]) begin
      dma_done <= 1'b1;
    end else if (wr_fire && avs_address == OFF_NORMAL_STATUS && avs_byteenable[1]
                 && avs_writedata[DONE_BIT]) begin
      dma_done <= 1'b0;
    end
  end

  // ==========
  // Reply buffer
  pcdma_fifo #(
    .WIDTH (34),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (rx_valid),
    .in_data   ({rx_error, rx_last, rx_data}),
    .in_ready  (rx_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_pop)
  );

  assign fifo_pop  = state_reg == S_RX && fifo_valid;
  assign timed_out = timeout_reg >= {1'b0, link_control[31:16]} && !fifo_valid;
  assign mm_done   = (mm_read || mm_write) && !mm_waitrequest;

  pcdma_rx_select u_select (
    .rx_error   (fifo_valid && fifo_data[33]),
    .timed_out  (timed_out),
    .got_word   (got_word_reg),
    .rx_word    (fifo_data[31:0]),
    .base_addr  (reply_base_reg),
    .write_addr (write_ptr_reg),
    .store_addr (store_addr),
    .store_word (store_word)
  );

  // ==========
  // Reply timeout counter
  always_ff @(posedge clk) begin
    if (reset || state_reg != S_RX || fifo_valid) begin
      timeout_reg <= '0;
    end else if (!timed_out) begin
      timeout_reg <= timeout_reg + UNITS_PER_CLK;
    end
  end

  // ==========
  // Table walker
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg     <= S_IDLE;
      dma_busy      <= 1'b0;
      mm_address    <= '0;
      mm_read       <= 1'b0;
      mm_write      <= 1'b0;
      mm_writedata  <= '0;
      tx_valid      <= 1'b0;
      tx_data       <= '0;
      tx_last       <= 1'b0;
      tx_port       <= '0;
      header_reg    <= '0;
      reply_base_reg <= '0;
      write_ptr_reg <= '0;
      table_ptr_reg <= '0;
      tx_left_reg   <= '0;
      got_word_reg  <= 1'b0;
      reply_end_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          if (start && area_ok(table_base_reg, area_protect_reg)) begin
            dma_busy   <= 1'b1;
            mm_address <= table_base_reg;
            mm_read    <= 1'b1;
            state_reg  <= S_HDR;
          end
        end
        S_HDR: begin
          if (mm_done) begin
            header_reg  <= mm_readdata;
            tx_port     <= mm_readdata[PORT_LSB+1:PORT_LSB];
            tx_left_reg <= {1'b0, mm_readdata[LEN_BITS-1:0]} + 1'b1;
            mm_address  <= mm_address + 32'h4;
            state_reg   <= S_RXA;
          end
        end
        S_RXA: begin
          if (mm_done) begin
            reply_base_reg <= mm_readdata;
            write_ptr_reg  <= mm_readdata;
            mm_address     <= mm_address + 32'h4;
            if (area_ok(mm_address + 32'h4, area_protect_reg)) begin
              state_reg <= S_RDTX;
            end else begin
              mm_read   <= 1'b0;
              dma_busy  <= 1'b0;
              state_reg <= S_IDLE;
            end
          end
        end
        S_RDTX: begin
          if (mm_done) begin
            mm_read     <= 1'b0;
            tx_valid    <= 1'b1;
            tx_data     <= mm_readdata;
            tx_last     <= tx_left_reg == 9'h1;
            tx_left_reg <= tx_left_reg - 9'h1;
            mm_address  <= mm_address + 32'h4;
            state_reg   <= S_TX;
          end
        end
        S_TX: begin
          if (tx_ready) begin
            tx_valid <= 1'b0;
            if (!engine_enable_reg) begin
              dma_busy  <= 1'b0;
              state_reg <= S_IDLE;
            end else if (tx_last) begin
              got_word_reg  <= 1'b0;
              table_ptr_reg <= mm_address;
              state_reg     <= S_RX;
            end else begin
              mm_read   <= 1'b1;
              state_reg <= S_RDTX;
            end
          end
        end
        S_RX: begin
          if (!engine_enable_reg) begin
            dma_busy  <= 1'b0;
            state_reg <= S_IDLE;
          end else if (fifo_valid || timed_out) begin
            if (area_ok(store_addr, area_protect_reg)) begin
              mm_address    <= store_addr;
              mm_writedata  <= store_word;
              mm_write      <= 1'b1;
              got_word_reg  <= 1'b1;
              reply_end_reg <= timed_out || fifo_data[33] || fifo_data[32];
              state_reg     <= S_WR;
            end else begin
              dma_busy  <= 1'b0;
              state_reg <= S_IDLE;
            end
          end
        end
        S_WR: begin
          if (mm_done) begin
            mm_write      <= 1'b0;
            write_ptr_reg <= write_ptr_reg + 32'h4;
            if (!reply_end_reg) begin
              state_reg <= S_RX;
            end else if (header_reg[LAST_BIT] || !engine_enable_reg) begin
              dma_busy  <= 1'b0;
              state_reg <= S_IDLE;
            end else if (area_ok(table_ptr_reg, area_protect_reg)) begin
              mm_address <= table_ptr_reg;
              mm_read    <= 1'b1;
              state_reg  <= S_HDR;
            end else begin
              dma_busy  <= 1'b0;
              state_reg <= S_IDLE;
            end
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule // peripheral_command_dma
`default_nettype wire

// ---- tb/pcdma_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module pcdma_asserts
  import pcdma_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [23:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [31:0] mm_address,
  input wire logic        mm_read,
  input wire logic        mm_waitrequest,
  input wire logic        hw_trigger,
  input wire logic        tx_valid,
  input wire logic [31:0] tx_data,
  input wire logic        tx_ready,
  input wire logic [31:0] link_control,
  input wire logic        dma_busy,
  input wire logic        dma_done
);
  // ==========
  // Shadow of enable and trigger select
  logic en_reg;
  logic trig_reg;
  logic wr_ok;
  logic cfg_wr;
  logic clr_done;
  logic go;
  assign wr_ok    = avs_write && !avs_waitrequest;
  assign cfg_wr   = wr_ok && avs_byteenable == 4'hF;
  assign clr_done = wr_ok && avs_address == OFF_NORMAL_STATUS && avs_byteenable[1]
                    && avs_writedata[DONE_BIT];
  assign go       = wr_ok && avs_address == OFF_START_STATUS && avs_byteenable[0]
                    && avs_writedata[0];
  always_ff @(posedge clk) begin
    if (reset) begin
      en_reg   <= 1'h0;
      trig_reg <= 1'h0;
    end else if (cfg_wr && avs_address == OFF_ENGINE_ENABLE) begin
      en_reg <= avs_writedata[0];
    end else if (cfg_wr && avs_address == OFF_TRIGGER_SELECT) begin
      trig_reg <= avs_writedata[0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ==========
  // Properties
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
  AST_IDLE: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low without request");
  AST_READ_BUSY: assert property (avs_read && !avs_waitrequest && avs_address == OFF_START_STATUS
    |-> avs_readdata == {31'h0, $past(dma_busy)})
    else $error("status read does not match busy");
  AST_START: assert property (go && en_reg && !trig_reg && !dma_busy |=> dma_busy)
    else $error("software start did not launch");
  AST_HW_START: assert property (hw_trigger && en_reg && trig_reg && !dma_busy |=> dma_busy)
    else $error("hardware trigger did not launch");
  AST_OFF_IDLE: assert property (!en_reg && !dma_busy |=> !dma_busy)
    else $error("transfer started while disabled");
  AST_DONE_HOLD: assert property (dma_done && !clr_done |=> dma_done)
    else $error("done flag lost without clear");
  AST_DONE_CLEAR: assert property (clr_done && !dma_busy |=> !dma_done)
    else $error("done flag not cleared");
  AST_DONE_END: assert property ($rose(dma_done) |-> $fell(dma_busy))
    else $error("done flag rose outside transfer end");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("frame word dropped before accepted");
  AST_MM_HOLD: assert property (mm_read && mm_waitrequest |=> mm_read && $stable(mm_address))
    else $error("memory read dropped before answer");
  AST_LINK: assert property (cfg_wr && avs_address == OFF_LINK_CONTROL
    |=> link_control == $past(avs_writedata))
    else $error("link control not updated");
endmodule // pcdma_asserts

bind peripheral_command_dma pcdma_asserts u_asserts (
  .clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_readdata, .avs_waitrequest, .mm_address, .mm_read, .mm_waitrequest, .hw_trigger,
  .tx_valid, .tx_data, .tx_ready, .link_control, .dma_busy, .dma_done);
`default_nettype wire

// ---- tb/pcdma_partner.sv ----
`timescale 1ns/10ps
`default_nettype none
module pcdma_partner (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        slow,
  input  wire logic [7:0]  port_mode,
  input  wire logic [31:0] mm_address,
  input  wire logic        mm_read,
  input  wire logic        mm_write,
  input  wire logic [31:0] mm_writedata,
  output logic      [31:0] mm_readdata,
  output logic             mm_waitrequest,
  input  wire logic        tx_valid,
  input  wire logic [31:0] tx_data,
  input  wire logic        tx_last,
  input  wire logic [1:0]  tx_port,
  output logic             tx_ready,
  output logic             rx_valid,
  output logic      [31:0] rx_data,
  output logic             rx_last,
  output logic             rx_error,
  input  wire logic        rx_ready
);
  logic [31:0] mem [logic [31:0]];
  logic [33:0] tx_log [$];
  logic [1:0]  wait_cnt, rport, rmode;
  logic [5:0]  idx;
  logic [31:0] word;
  // ==========
  // Memory slave, answers after one wait or, when slow, after three waits
  always @(posedge clk) begin
    if (reset) begin
      mm_waitrequest <= 1'h1;
      wait_cnt <= 2'h0;
      mm_readdata <= 32'h0;
    end else begin
      mm_waitrequest <= 1'h1;
      if (!mm_waitrequest) begin
        wait_cnt <= 2'h0;
        mm_readdata <= ~mm_readdata;
        if (mm_write) mem[mm_address] = mm_writedata;
      end else if (mm_read || mm_write) begin
        wait_cnt <= wait_cnt + 2'h1;
        if (wait_cnt == {slow, 1'h0}) begin
          mm_waitrequest <= 1'h0;
          mm_readdata <= mem.exists(mm_address) ? mem[mm_address] : 32'h0;
        end
      end
    end
  end
  // ==========
  // Peripheral: mode 0 status reply, 1 absent, 2 broken reply
  always @(posedge clk) begin
    if (reset) begin
      tx_ready <= 1'h0;
      rx_valid <= 1'h0;
      idx <= 6'h0;
    end else begin
      tx_ready <= !slow || !tx_ready;
      if (tx_valid && tx_ready) begin
        tx_log.push_back({tx_port, tx_data});
        if (tx_last) begin
          rport <= tx_port;
          rmode <= port_mode[2*tx_port +: 2];
          idx <= 6'h0;
          rx_valid <= port_mode[2*tx_port +: 2] != 2'h1;
        end
      end
      if (rx_valid && rx_ready) begin
        idx <= idx + 6'h1;
        if (rx_last || rx_error) rx_valid <= 1'h0;
      end
    end
  end
  assign word     = (idx == 6'h0) ? 32'h0500201C : {14'h0, rport, 10'h0, idx};
  assign rx_data  = rx_valid ? word : ~word;
  assign rx_last  = rx_valid && rmode == 2'h0 && idx == 6'h1C;
  assign rx_error = rx_valid && rmode == 2'h2 && idx == 6'h1;
endmodule // pcdma_partner
`default_nettype wire

// ---- tb/peripheral_command_dma_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module peripheral_command_dma_tb_top;
  import pcdma_pkg::*;
  typedef struct {logic wr; logic [23:0] a; logic [31:0] d;} row_s;
  logic        clk, reset, avs_read, avs_write, avs_waitrequest, mm_read, mm_write;
  logic        mm_waitrequest, hw_trigger, tx_valid, tx_last, tx_ready, rx_valid;
  logic        rx_last, rx_error, rx_ready, dma_busy, dma_done, slow;
  logic [23:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, mm_address, mm_writedata, mm_readdata;
  logic [31:0] tx_data, rx_data, link_control, rd;
  logic [3:0]  avs_byteenable;
  logic [1:0]  tx_port;
  logic [7:0]  port_mode;
  int          num_errors, total_checks;
  row_s        rows [18];
  logic [31:0] tbl [13] = '{32'h0, 32'h0C800000, 32'h01200000, 32'h00010000, 32'h0C800100,
    32'h01604000, 32'h00020000, 32'h0C800200, 32'h01A08000, 32'h80030001, 32'h0C800300,
    32'h09E0C001, 32'h1};
  logic [33:0] exp_tx [5] = '{34'h001200000, 34'h101604000, 34'h201A08000, 34'h309E0C001,
    34'h300000001};

  peripheral_command_dma #(.FIFO_DEPTH(8)) dut (.clk, .reset, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .mm_address,
    .mm_read, .mm_write, .mm_writedata, .mm_readdata, .mm_waitrequest, .hw_trigger, .tx_valid,
    .tx_data, .tx_last, .tx_port, .tx_ready, .rx_valid, .rx_data, .rx_last, .rx_error,
    .rx_ready, .link_control, .dma_busy, .dma_done);
  pcdma_partner u_partner (.clk, .reset, .slow, .port_mode, .mm_address, .mm_read, .mm_write,
    .mm_writedata, .mm_readdata, .mm_waitrequest, .tx_valid, .tx_data, .tx_last, .tx_port,
    .tx_ready, .rx_valid, .rx_data, .rx_last, .rx_error, .rx_ready);

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // ==========
  // Bus master, comparison and closing
  task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [23:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 100);
    q = avs_readdata;
    chk("bus answer", 34'h0, {33'h0, avs_waitrequest});
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge clk);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========
  // One pass through the command table
  task automatic run_table(input string name, input logic hw);
    int n;
    u_partner.mem.delete();
    u_partner.tx_log.delete();
    foreach (tbl[i]) u_partner.mem[32'h0C700000 + 32'(4 * i)] = tbl[i];
    bus(1'h1, OFF_NORMAL_STATUS, 32'h00001000, rd);
    if (hw) begin
      hw_trigger <= 1'h1;
      @(posedge clk);
      hw_trigger <= 1'h0;
    end else bus(1'h1, OFF_START_STATUS, 32'h1, rd);
    bus(1'h0, OFF_START_STATUS, 32'h0, rd);
    chk("busy read", 34'h1, {2'h0, rd});
    n = 0;
    while (dma_done !== 1'h1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    chk("done flag", 34'h1, {33'h0, dma_done});
    chk("reply 0 head", 34'h0500201C, {2'h0, u_partner.mem[32'h0C800000]});
    chk("reply 0 tail", 34'h0000001C, {2'h0, u_partner.mem[32'h0C800070]});
    chk("no link", 34'hFFFFFFFF, {2'h0, u_partner.mem[32'h0C800100]});
    chk("rx error", 34'hFFFFFF00, {2'h0, u_partner.mem[32'h0C800200]});
    chk("reply 3 tail", 34'h0003001C, {2'h0, u_partner.mem[32'h0C800370]});
    chk("tx count", 34'h5, 34'(u_partner.tx_log.size()));
    for (int i = 0; i < 5; i++) chk("tx word", exp_tx[i], u_partner.tx_log[i]);
    bus(1'h0, OFF_NORMAL_STATUS, 32'h0, rd);
    chk("status flag", 34'h00001000, {2'h0, rd});
    bus(1'h0, OFF_START_STATUS, 32'h0, rd);
    chk("idle read", 34'h0, {2'h0, rd});
    bus(1'h1, OFF_NORMAL_STATUS, 32'h00001000, rd);
    bus(1'h0, OFF_NORMAL_STATUS, 32'h0, rd);
    chk("status clear", 34'h0, {2'h0, rd});
    $display("test %s finished", name);
  endtask
  // ==========
  // Main sequence
  initial begin
    rows = '{'{1'h1, OFF_ENGINE_ENABLE, 32'h0}, '{1'h0, OFF_ENGINE_ENABLE, 32'h0},
      '{1'h0, OFF_START_STATUS, 32'h0}, '{1'h1, OFF_LINK_CONTROL, 32'hC3500000},
      '{1'h0, OFF_LINK_CONTROL, 32'hC3500000}, '{1'h1, OFF_TRIGGER_SELECT, 32'h1},
      '{1'h0, OFF_TRIGGER_SELECT, 32'h1}, '{1'h1, OFF_TRIGGER_SELECT, 32'h0},
      '{1'h0, OFF_TRIGGER_SELECT, 32'h0}, '{1'h1, OFF_AREA_PROTECT, 32'h6155007F},
      '{1'h1, OFF_TABLE_BASE, 32'h1C700000}, '{1'h0, OFF_TABLE_BASE, 32'h0C000000},
      '{1'h1, OFF_TABLE_BASE, 32'h0C700000}, '{1'h0, OFF_TABLE_BASE, 32'h0C700000},
      '{1'h0, 24'h5F6C00, 32'h0}, '{1'h1, OFF_LINK_CONTROL, 32'h00640000},
      '{1'h1, OFF_ENGINE_ENABLE, 32'h1}, '{1'h0, OFF_ENGINE_ENABLE, 32'h1}};
    reset = 1'h1;
    {avs_read, avs_write, hw_trigger, slow} = 4'h0;
    avs_address = 24'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    port_mode = 8'h24;
    repeat (6) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].a, rows[i].d, rd);
      if (!rows[i].wr) chk($sformatf("reg %h", rows[i].a), {2'h0, rows[i].d}, {2'h0, rd});
    end
    $display("test registers finished");
    run_table("software start", 1'h0);
    slow <= 1'h1;
    run_table("restart stalled", 1'h0);
    slow <= 1'h0;
    bus(1'h1, OFF_ENGINE_ENABLE, 32'h0, rd);
    bus(1'h1, OFF_TRIGGER_SELECT, 32'h1, rd);
    bus(1'h1, OFF_ENGINE_ENABLE, 32'h1, rd);
    run_table("hardware start", 1'h1);
    bus(1'h1, OFF_ENGINE_ENABLE, 32'h0, rd);
    bus(1'h1, OFF_TRIGGER_SELECT, 32'h0, rd);
    bus(1'h1, OFF_START_STATUS, 32'h1, rd);
    bus(1'h0, OFF_START_STATUS, 32'h0, rd);
    chk("start while off", 34'h0, {2'h0, rd});
    reset <= 1'h1;
    repeat (6) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    bus(1'h0, OFF_TABLE_BASE, 32'h0, rd);
    chk("base after reset", 34'h0C000000, {2'h0, rd});
    bus(1'h0, OFF_ENGINE_ENABLE, 32'h0, rd);
    chk("enable after reset", 34'h0, {2'h0, rd});
    $display("test reset finished");
    complete_run();
  end
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule // peripheral_command_dma_tb_top
`default_nettype wire
